// *** prot_pkg.sv ***
// prot_pkg: request codes, priority ranks, protection-word layout, register map
// assumes: a 32-bit axi4-lite register slave and a peer end that exchanges the 13-bit word
package prot_pkg;
  // ------------------------------------------------------------
  // request type codes
  // ------------------------------------------------------------
  localparam logic [3:0] REQ_NO_REQUEST = 4'h0;
  localparam logic [3:0] REQ_DO_NOT_REVERT = 4'h1;
  localparam logic [3:0] REQ_REVERSE_REQUEST = 4'h2;
  localparam logic [3:0] REQ_EXERCISE = 4'h4;
  localparam logic [3:0] REQ_WAIT_TO_RESTORE = 4'h6;
  localparam logic [3:0] REQ_MANUAL_SWITCH = 4'h8;
  localparam logic [3:0] REQ_DEGRADE_LOW = 4'ha;
  localparam logic [3:0] REQ_DEGRADE_HIGH = 4'hb;
  localparam logic [3:0] REQ_FAIL_LOW = 4'hc;
  localparam logic [3:0] REQ_FAIL_HIGH = 4'hd;
  localparam logic [3:0] REQ_FORCED_SWITCH = 4'he;
  localparam logic [3:0] REQ_LOCKOUT = 4'hf;
  // ------------------------------------------------------------
  // priority ranks, larger wins
  // ------------------------------------------------------------
  localparam logic [3:0] PR_INVALID = 4'h0;
  localparam logic [3:0] PR_NO_REQUEST = 4'h1;
  localparam logic [3:0] PR_DO_NOT_REVERT = 4'h2;
  localparam logic [3:0] PR_REVERSE = 4'h3;
  localparam logic [3:0] PR_EXERCISE = 4'h4;
  localparam logic [3:0] PR_WAIT_TO_RESTORE = 4'h5;
  localparam logic [3:0] PR_MANUAL = 4'h6;
  localparam logic [3:0] PR_DEGRADE_LOW = 4'h7;
  localparam logic [3:0] PR_DEGRADE_HIGH = 4'h8;
  localparam logic [3:0] PR_FAIL_LOW = 4'h9;
  localparam logic [3:0] PR_FAIL_HIGH = 4'ha;
  localparam logic [3:0] PR_FORCED = 4'hb;
  localparam logic [3:0] PR_PROT_FAIL = 4'hc;
  localparam logic [3:0] PR_LOCKOUT = 4'hd;
  // ------------------------------------------------------------
  // protection word layout (bit 12 = first byte bit 1)
  // ------------------------------------------------------------
  localparam int WORD_W = 13;
  localparam int TYPE_MSB = 12;
  localparam int REQNUM_MSB = 8;
  localparam int BSN_MSB = 4;
  localparam int ARCH_POS = 0;
  localparam int NUM_W = 4;
  localparam logic ARCH_ONE_PLUS_ONE = 1'b0;
  localparam logic ARCH_ONE_TO_N = 1'b1;
  // ------------------------------------------------------------
  // register map (byte offsets)
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_COND = 8'h04;
  localparam logic [7:0] REG_EXT = 8'h08;
  localparam logic [7:0] REG_STATE = 8'h0c;
  localparam logic [7:0] REG_TX = 8'h10;
  localparam logic [7:0] REG_RX = 8'h14;
  localparam logic [7:0] REG_LOCAL = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage : prot_pkg

// *** rank_if.sv ***
// rank_if: request type in, priority rank out, between top and ranker
// assumes: combinational ranker on the same clock
`timescale 1ns/1ps
`default_nettype none
interface rank_if;
  logic [3:0] code;
  logic prot_path;
  logic aps_on;
  logic [3:0] rank;
  logic known;
  modport user (output code, output prot_path, output aps_on, input rank, input known);
  modport ranker (input code, input prot_path, input aps_on, output rank, output known);
endinterface : rank_if
`default_nettype wire

// *** request_ranker.sv ***
// request_ranker: maps a request code to its priority rank
// assumes: driven from the top through rank_if
`timescale 1ns/1ps
`default_nettype none
module request_ranker (
  rank_if.ranker r
);
  import prot_pkg::*;
  // ------------------------------------------------------------
  // ranking
  // ------------------------------------------------------------
  always_comb begin
    r.known = 1'b1;
    case (r.code)
      REQ_LOCKOUT: r.rank = PR_LOCKOUT;
      REQ_FORCED_SWITCH: r.rank = PR_FORCED;
      REQ_FAIL_HIGH, REQ_FAIL_LOW: begin
        // protection-path fail beats forced only with signalling
        if (r.prot_path && r.aps_on) begin
          r.rank = PR_PROT_FAIL;
        end else if (r.code == REQ_FAIL_HIGH) begin
          r.rank = PR_FAIL_HIGH;
        end else begin
          r.rank = PR_FAIL_LOW;
        end
      end
      REQ_DEGRADE_HIGH: r.rank = PR_DEGRADE_HIGH;
      REQ_DEGRADE_LOW: r.rank = PR_DEGRADE_LOW;
      REQ_MANUAL_SWITCH: r.rank = PR_MANUAL;
      REQ_WAIT_TO_RESTORE: r.rank = PR_WAIT_TO_RESTORE;
      REQ_EXERCISE: r.rank = PR_EXERCISE;
      REQ_REVERSE_REQUEST: r.rank = PR_REVERSE;
      REQ_DO_NOT_REVERT: r.rank = PR_DO_NOT_REVERT;
      REQ_NO_REQUEST: r.rank = PR_NO_REQUEST;
      default: begin
        r.rank = PR_INVALID;
        r.known = 1'b0;
      end
    endcase
  end
endmodule : request_ranker
`default_nettype wire

// *** protection_codec.sv ***
// protection_codec: host-side request priority and protection word packer
// assumes: axi4-lite software port, peer word exchanged on tx_word/rx_word
// Contract
// - request type is four bits
// - codes for no request through manual
// - codes for degrade through lockout
// - requested number binary, parameter width
// - number zero is protection path or null
// - one to max are working; one-plus-one only one; only ext is checked, state numbers up to max+1 and paths up to n still pass
// - max plus one is extra traffic, commands only; only ext is checked, a state of any type may carry max+1
// - bridged zero null, max+1 extra traffic
// - architecture bit zero one-plus-one, one one-to-n
// - word is thirteen bits, four groups
// - byte one type and number, byte two bridged, arch
`timescale 1ns/1ps
`default_nettype none
module protection_codec #(
  parameter int N_MAX = 14
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr_lo,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [prot_pkg::WORD_W-1:0] tx_word,
  input wire logic [prot_pkg::WORD_W-1:0] rx_word
);
  import prot_pkg::*;
  localparam int NP = N_MAX + 1;

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [31:0] cond;
    logic [31:0] ext;
    logic [31:0] state;
    logic [WORD_W-1:0] rx1;
    logic [WORD_W-1:0] rx2;
    logic [WORD_W-1:0] rx3;
    logic [WORD_W-1:0] rx_stable;
    logic [3:0] lrt;
    logic [NUM_W-1:0] lrsn;
    logic [WORD_W-1:0] tx;
  } st_s;
  st_s q, d;

  // ------------------------------------------------------------
  // register fields
  // ------------------------------------------------------------
  // ctrl: [0] arch one-to-n, [1] signalling on, [2] section mode,
  // [3] fail_priority_setting high, [4] degrade_priority_setting high,
  // [11:8] bridged number, [15:12] working path count n
  // cond: [2i] fail, [2i+1] degrade, path i=0..14
  // ext: [3:0] external request type, [7:4] its number
  // state: [3:0] process state type, [7:4] its number
  logic arch_n, aps_on, sec_mode, fail_pri_hi, degrade_pri_hi;
  assign arch_n = q.ctrl[0];
  assign aps_on = q.ctrl[1];
  assign sec_mode = q.ctrl[2];
  assign fail_pri_hi = q.ctrl[3];
  assign degrade_pri_hi = q.ctrl[4];

  // path condition to request type; path 0 is protection
  // mode bits passed in so the per-path assigns re-evaluate when they change
  function automatic logic [3:0] cond_code(input logic f, input logic g, input logic prot,
      input logic sec, input logic an, input logic fhi, input logic dhi);
    logic hi_f;
    logic hi_g;
    hi_f = 1'b1;
    hi_g = 1'b1;
    // one-to-n section mode: working priorities provisionable
    if (sec && an && !prot) begin
      hi_f = fhi;
      hi_g = dhi;
    end
    // otherwise fixed high; also the no-priority path case
    if (f) begin
      cond_code = hi_f ? REQ_FAIL_HIGH : REQ_FAIL_LOW;
    end else if (g) begin
      cond_code = hi_g ? REQ_DEGRADE_HIGH : REQ_DEGRADE_LOW;
    end else begin
      cond_code = REQ_NO_REQUEST;
    end
  endfunction : cond_code

  // number validity for a request type
  function automatic logic num_ok(input logic [3:0] rt, input logic [NUM_W-1:0] n);
    logic cmd;
    cmd = (rt == REQ_FORCED_SWITCH) || (rt == REQ_MANUAL_SWITCH) || (rt == REQ_EXERCISE);
    if (n == '0) begin
      num_ok = (rt != REQ_EXERCISE);
    end else if (n == NUM_W'(N_MAX + 1)) begin
      num_ok = cmd && arch_n;
    end else if (!arch_n) begin
      num_ok = (n == NUM_W'(1));
    end else begin
      num_ok = (n <= NUM_W'(N_MAX));
    end
  endfunction : num_ok

  // ------------------------------------------------------------
  // per-path ranks through ranker instances
  // ------------------------------------------------------------
  logic [3:0] p_code [NP];
  logic [3:0] p_rank [NP];
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_path
      rank_if ri ();
      request_ranker u_rank (.r(ri.ranker));
      assign p_code[gi] = cond_code(q.cond[2*gi], q.cond[2*gi+1], gi == 0, sec_mode, arch_n,
          fail_pri_hi, degrade_pri_hi);
      assign ri.code = p_code[gi];
      assign ri.prot_path = (gi == 0);
      assign ri.aps_on = aps_on;
      assign p_rank[gi] = ri.rank;
    end
  endgenerate

  rank_if ext_if ();
  request_ranker u_ext (.r(ext_if.ranker));
  assign ext_if.code = q.ext[3:0];
  assign ext_if.prot_path = 1'b0;
  assign ext_if.aps_on = aps_on;

  rank_if st_if ();
  request_ranker u_st (.r(st_if.ranker));
  assign st_if.code = q.state[3:0];
  assign st_if.prot_path = 1'b0;
  assign st_if.aps_on = aps_on;

  rank_if cur_if ();
  request_ranker u_cur (.r(cur_if.ranker));
  assign cur_if.code = q.lrt;
  assign cur_if.prot_path = (q.lrsn == '0);
  assign cur_if.aps_on = aps_on;

  // received peer word; low-priority conditions accepted as ranked
  rank_if rx_if ();
  request_ranker u_rx (.r(rx_if.ranker));
  assign rx_if.code = q.rx_stable[TYPE_MSB -: 4];
  assign rx_if.prot_path = (q.rx_stable[REQNUM_MSB -: NUM_W] == '0);
  assign rx_if.aps_on = aps_on;

  // ------------------------------------------------------------
  // local priority selection
  // ------------------------------------------------------------
  logic [3:0] best_rank, best_code;
  logic [NUM_W-1:0] best_num;
  logic cur_tie;
  always_comb begin
    best_rank = ext_if.rank;
    best_code = q.ext[3:0];
    best_num = q.ext[7:4];
    if (!num_ok(q.ext[3:0], q.ext[7:4])) begin
      best_rank = PR_INVALID;
    end
    // an out-of-range state number is ignored rather than sent
    if (st_if.rank > best_rank && q.state[7:4] <= NUM_W'(N_MAX + 1)) begin
      best_rank = st_if.rank;
      best_code = q.state[3:0];
      best_num = q.state[7:4];
    end
    cur_tie = 1'b0;
    // strict compare keeps the lowest path on a tie
    for (int i = 0; i < NP; i++) begin
      if (p_code[i] != REQ_NO_REQUEST && i <= int'(q.ctrl[15:12])) begin
        if (p_rank[i] > best_rank) begin
          best_rank = p_rank[i];
          best_code = p_code[i];
          best_num = NUM_W'(i);
          cur_tie = 1'b0;
        end
        // current local request holds against equal lower paths
        if (p_rank[i] == best_rank && p_code[i] == q.lrt && NUM_W'(i) == q.lrsn
            && best_code == q.lrt) begin
          cur_tie = 1'b1;
        end
      end
    end
    if (cur_tie) begin
      best_num = q.lrsn;
    end
    if (best_rank == PR_INVALID) begin
      best_code = REQ_NO_REQUEST;
      best_num = '0;
    end
  end

  // ------------------------------------------------------------
  // axi4-lite slave and state update
  // ------------------------------------------------------------
  logic wr_fire;
  always_comb begin
    d = q;
    d.rx1 = rx_word;
    d.rx2 = q.rx1;
    d.rx3 = q.rx2;
    // a change counts once two stages agree
    if (q.rx2 == q.rx3) begin
      d.rx_stable = q.rx3;
    end
    d.lrt = best_code;
    d.lrsn = best_num;
    // pack: type, requested, bridged, arch
    d.tx = {best_code, best_num, q.ctrl[11:8], arch_n};
    if (s_axi_awvalid && !q.aw_got) begin
      d.aw_got = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_got) begin
      d.w_got = 1'b1;
      d.w_data = s_axi_wdata;
    end
    wr_fire = q.aw_got && q.w_got && !q.bvalid;
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case (q.aw_addr)
        REG_CTRL: d.ctrl = q.w_data;
        REG_COND: d.cond = q.w_data;
        REG_EXT: d.ext = q.w_data;
        REG_STATE: d.state = q.w_data;
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: d.rdata = q.ctrl;
        REG_COND: d.rdata = q.cond;
        REG_EXT: d.rdata = q.ext;
        REG_STATE: d.rdata = q.state;
        REG_TX: d.rdata = {19'h0, q.tx};
        // bit 20 flags an unassigned received type
        REG_RX: d.rdata = {11'h0, ~rx_if.known, rx_if.rank, 3'h0, q.rx_stable};
        REG_LOCAL: d.rdata = {20'h0, cur_if.rank, q.lrsn, q.lrt};
        default: begin
          d.rdata = RESET_ZERO;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = !q.aw_got;
  assign s_axi_wready = !q.w_got;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign tx_word = q.tx;
endmodule : protection_codec
`default_nettype wire

// *** protection_codec_properties.sv ***
// protection_codec_properties: port-level checks on the codec
// assumes: bound onto protection_codec from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module protection_codec_properties #(
  parameter int N_MAX = 14
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [prot_pkg::WORD_W-1:0] tx_word
);
  import prot_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // handshake steps
  // ------------------------------------------------------------
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_aw_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // ------------------------------------------------------------
  // bus and wire properties
  // ------------------------------------------------------------
  a_write_answer: assert property (s_aw_w_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data moved");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response moved");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read data");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp != RESP_OKAY |->
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("error read not clean");
  a_tx_codes: assert property (!(tx_word[12:9] inside {4'h3, 4'h5, 4'h7, 4'h9}))
    else $error("unassigned type sent");
  a_reqnum_range: assert property (tx_word[8:5] <= N_MAX + 1)
    else $error("requested number out of range");
  a_bsn_range: assert property (tx_word[4:1] <= N_MAX + 1)
    else $error("bridged number out of range");
  a_reset_clear: assert property (disable iff (1'b0) !aresetn |=>
    tx_word == 13'h0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not cleared by reset");
endmodule : protection_codec_properties
`default_nettype wire

// *** peer_end.sv ***
// peer_end: far-end protection process, sends and unpacks the 13-bit word
// assumes: same clock as the codec; bench sets the fields to send
`timescale 1ns/1ps
`default_nettype none
module peer_end (
  input wire logic aclk,
  input wire logic [3:0] send_type,
  input wire logic [3:0] send_num,
  input wire logic [3:0] send_bridged,
  input wire logic send_arch,
  input wire logic [prot_pkg::WORD_W-1:0] tx_word,
  output logic [prot_pkg::WORD_W-1:0] rx_word,
  output logic [3:0] got_type,
  output logic [3:0] got_num,
  output logic [3:0] got_bridged,
  output logic got_arch
);
  import prot_pkg::*;
  // registered so the codec sees a clean word change
  always_ff @(posedge aclk) begin
    rx_word <= {send_type, send_num, send_bridged, send_arch};
  end
  assign {got_type, got_num, got_bridged, got_arch} = tx_word;
endmodule : peer_end
`default_nettype wire

// *** tb_protection_codec.sv ***
// tb_protection_codec: register-level tests of the protection codec
// assumes: codec, ranker, interface and peer model compiled before
`timescale 1ns/1ps
`default_nettype none
module tb_protection_codec;
  import prot_pkg::*;
  localparam int N_MAX = 6;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h0;
  logic [7:0] araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [12:0] tx_word, rx_word;
  logic [3:0] p_type = 4'h0, g_type, g_num, g_br;
  logic g_arch;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [3:0] rank_of [16] = '{PR_NO_REQUEST, PR_DO_NOT_REVERT, PR_REVERSE, PR_INVALID,
    PR_EXERCISE, PR_INVALID, PR_WAIT_TO_RESTORE, PR_INVALID, PR_MANUAL, PR_INVALID,
    PR_DEGRADE_LOW, PR_DEGRADE_HIGH, PR_FAIL_LOW, PR_FAIL_HIGH, PR_FORCED, PR_LOCKOUT};
  logic [3:0] ext_t [4] = '{REQ_FORCED_SWITCH, REQ_LOCKOUT, REQ_MANUAL_SWITCH, REQ_EXERCISE};
  logic [3:0] ext_n [4] = '{4'h7, 4'h0, 4'h1, 4'h1};
  logic [3:0] ext_r [4] = '{PR_FORCED, PR_LOCKOUT, PR_MANUAL, PR_EXERCISE};
  protection_codec #(.N_MAX(N_MAX)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr_lo(4'h0), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_word(tx_word), .rx_word(rx_word));
  peer_end peer (.aclk(aclk), .send_type(p_type), .send_num(4'h1), .send_bridged(4'h2),
    .send_arch(1'b1), .tx_word(tx_word), .rx_word(rx_word), .got_type(g_type),
    .got_num(g_num), .got_bridged(g_br), .got_arch(g_arch));
  // ------------------------------------------------------------
  // clock, watchdog, bus tasks
  // ------------------------------------------------------------
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // values read right after the edge are the ones sampled at it
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_read
  task automatic expect_local(input logic [3:0] t, input logic [3:0] n, input logic [3:0] rk);
    repeat (4) @(posedge aclk);
    axi_read(REG_LOCAL, rd, resp);
    check("local request", {20'h0, rk, n, t}, {20'h0, rd[11:0]});
    check("sent request", {24'h0, t, n}, {24'h0, g_type, g_num});
  endtask : expect_local
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(REG_CTRL, rd, resp);
    check("ctrl reset", RESET_ZERO, rd);
    check("tx reset", 32'h0, {19'h0, tx_word});
    axi_read(8'h1c, rd, resp);
    check("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    check("unmapped data", 32'h0, rd);
    axi_write(REG_TX, 32'h1, resp);
    check("ro write resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axi_write(REG_CTRL, 32'h0000_4301, resp);
    repeat (4) @(posedge aclk);
    check("tx bridged", 32'h3, {28'h0, g_br});
    check("tx arch", {31'h0, ARCH_ONE_TO_N}, {31'h0, g_arch});
    for (int i = 0; i < 4; i++) begin
      axi_write(REG_EXT, {24'h0, ext_n[i], ext_t[i]}, resp);
      expect_local(ext_t[i], ext_n[i], ext_r[i]);
    end
    axi_write(REG_EXT, 32'h0, resp);
    axi_write(REG_COND, 32'h4, resp);
    expect_local(REQ_FAIL_HIGH, 4'h1, PR_FAIL_HIGH);
    axi_write(REG_CTRL, 32'h0000_4305, resp);
    expect_local(REQ_FAIL_LOW, 4'h1, PR_FAIL_LOW);
    axi_write(REG_COND, 32'h5, resp);
    expect_local(REQ_FAIL_HIGH, 4'h0, PR_FAIL_HIGH);
    axi_write(REG_COND, 32'h50, resp);
    expect_local(REQ_FAIL_LOW, 4'h2, PR_FAIL_LOW);
    // path 1 joins at the same type: the current path 2 is kept
    axi_write(REG_COND, 32'h54, resp);
    expect_local(REQ_FAIL_LOW, 4'h2, PR_FAIL_LOW);
    axi_write(REG_COND, 32'h1, resp);
    axi_write(REG_EXT, 32'h2e, resp);
    axi_write(REG_CTRL, 32'h0000_4307, resp);
    expect_local(REQ_FAIL_HIGH, 4'h0, PR_PROT_FAIL);
    axi_write(REG_CTRL, 32'h0000_4305, resp);
    expect_local(REQ_FORCED_SWITCH, 4'h2, PR_FORCED);
    // exercise on number zero is refused, so no request remains
    axi_write(REG_COND, 32'h0, resp);
    axi_write(REG_EXT, 32'h04, resp);
    expect_local(REQ_NO_REQUEST, 4'h0, PR_NO_REQUEST);
    axi_write(REG_STATE, 32'h16, resp);
    expect_local(REQ_WAIT_TO_RESTORE, 4'h1, PR_WAIT_TO_RESTORE);
    axi_write(REG_EXT, 32'h14, resp);
    expect_local(REQ_WAIT_TO_RESTORE, 4'h1, PR_WAIT_TO_RESTORE);
    // every received code, assigned or not, through the rank table
    for (int c = 0; c < 16; c++) begin
      p_type <= c[3:0];
      repeat (6) @(posedge aclk);
      axi_read(REG_RX, rd, resp);
      check("rx word", {19'h0, c[3:0], 9'h025}, {19'h0, rd[12:0]});
      check("rx rank", {28'h0, rank_of[c]}, {28'h0, rd[19:16]});
      check("rx unknown", {31'h0, rank_of[c] == PR_INVALID}, {31'h0, rd[20]});
    end
    stop_test();
  end
endmodule : tb_protection_codec
bind protection_codec protection_codec_properties #(.N_MAX(N_MAX)) u_props (.aclk,
  .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_word);
`default_nettype wire
